/* File: common/reload_capture_timer16_pkg.sv */
// Package of constants for the two-channel reload/capture timer.
// Assumes a single 125 MHz system clock and an APB register bus.
package reload_capture_timer16_pkg;

    // ==========================================================
    // Instances and timing
    // ==========================================================
    localparam int          NUM_TIMERS        = 2;
    localparam int          CLK_PERIOD_NS     = 8;
    localparam int          TICK_DIV_CYCLES   = 12;  // Timer tick period
    localparam int          MIN_EDGE_CYCLES   = 24;  // Counter input resolution
    // Counter pin sampled once per tick; two samples per edge
    localparam int          SAMPLES_PER_EDGE  = MIN_EDGE_CYCLES / TICK_DIV_CYCLES;

    // ==========================================================
    // Register map, one block of four words per timer
    // ==========================================================
    localparam logic [7:0]  TIMER_STRIDE      = 8'h10;
    localparam logic [3:0]  CTRL_OFS          = 4'h0;
    localparam logic [3:0]  FLAG_OFS          = 4'h4;
    localparam logic [3:0]  RELOAD_OFS        = 4'h8;
    localparam logic [3:0]  COUNT_OFS         = 4'hc;
    localparam logic [7:0]  MAP_LIMIT         = 8'h20;

    // ==========================================================
    // Control field positions
    // ==========================================================
    localparam int          RUN_BIT           = 0;
    localparam int          CAP_SEL_BIT       = 1;
    localparam int          UPDOWN_BIT        = 2;
    localparam int          EXT_EN_BIT        = 3;
    localparam int          COUNT_SRC_BIT     = 4;
    localparam int          HW_START_EN_BIT   = 5;
    localparam int          HW_START_EDGE_BIT = 6;
    localparam int          EXT_EDGE_BIT      = 7;
    localparam int          CTRL_WIDTH        = 8;

    // ==========================================================
    // Flag field positions
    // ==========================================================
    localparam int          OVF_FLAG_BIT      = 0;
    localparam int          EXT_FLAG_BIT      = 1;

    // ==========================================================
    // Values after reset and fixed reload values
    // ==========================================================
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [15:0] COUNT_RESET       = 16'h0000;
    localparam logic [15:0] RELOAD_RESET      = 16'h0000;
    localparam logic [15:0] COUNT_MAX         = 16'hffff;
    localparam logic [15:0] CAPTURE_RESTART   = 16'h0000;

endpackage : reload_capture_timer16_pkg

/* File: hdl/tick_divider.sv */
// Free-running divider giving a one-cycle enable every DIV clocks.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module tick_divider #(
    parameter int DIV = 12
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Enable out
    output logic      tick
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] divCount_reg;
    wire          atLast = (divCount_reg == LAST);

    // ==========================================================
    // Divider counter
    // ==========================================================
    // Wraps at DIV-1 and pulses the enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            divCount_reg <= '0;
            tick         <= 1'b0;
        end else begin
            divCount_reg <= atLast ? '0 : divCount_reg + W'(1);
            tick         <= atLast;
        end
    end
endmodule : tick_divider

/* File: hdl/pin_edge_sampler.sv */
// Samples a pin on an enable and reports its level and edges.
// Assumes the pin is synchronous to sys_clk; edges appear one clock after the sample.
`timescale 1ns/1ns
module pin_edge_sampler (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Sampling
    input  wire logic sampleEn,
    input  wire logic pinIn,
    // Results
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic primed_reg;

    // ==========================================================
    // Sample and compare with previous sample
    // ==========================================================
    // No edge before two samples have been taken
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level      <= 1'b0;
            primed_reg <= 1'b0;
            rise       <= 1'b0;
            fall       <= 1'b0;
        end else if (sampleEn) begin
            level      <= pinIn;
            primed_reg <= 1'b1;
            rise       <= primed_reg & pinIn & ~level;
            fall       <= primed_reg & ~pinIn & level;
        end else begin
            rise       <= 1'b0;
            fall       <= 1'b0;
        end
    end
endmodule : pin_edge_sampler

/* File: hdl/reload_capture_timer16.sv */
// Two independent 16-bit reload/capture timers behind an APB slave.
// Assumes APB signals and all pins synchronous to sys_clk at 125 MHz.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module reload_capture_timer16 #(
    parameter int NUM = reload_capture_timer16_pkg::NUM_TIMERS
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    // APB slave
    input  wire logic [7:0]      paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Timer pins, one per timer
    input  wire logic [NUM-1:0]  countInPin,
    input  wire logic [NUM-1:0]  externalTriggerPin,
    output logic      [NUM-1:0]  irqReq
);
    // ==========================================================
    // Helper functions
    // ==========================================================
    // Pick rising (sel high) or falling edge
    function automatic logic pickEdge(input logic rise, input logic fall, input logic sel);
        pickEdge = sel ? rise : fall;
    endfunction : pickEdge

    // Merge written bytes of a 16-bit register
    function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  strb);
        mergeBytes = {strb[1] ? wdata[15:8] : old[15:8], strb[0] ? wdata[7:0] : old[7:0]};
    endfunction : mergeBytes

    // ==========================================================
    // APB decode
    // ==========================================================
    wire              mapped   = (paddr < reload_capture_timer16_pkg::MAP_LIMIT)
                                 && (paddr[1:0] == 2'b00);
    wire              apbWr    = psel & penable & pwrite & mapped;
    wire              timerSel = paddr[4];
    wire logic [3:0]  regOfs   = paddr[3:0];

    logic [7:0]       ctrl_reg    [NUM];
    logic [15:0]      count_reg   [NUM];
    logic [15:0]      reload_reg  [NUM];
    logic [1:0]       flag_reg    [NUM];

    // Zero-wait slave, error on unmapped or misaligned address
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Read data registered from the addressed register
    wire logic [15:0] readSel =
        (regOfs == reload_capture_timer16_pkg::CTRL_OFS)   ? {8'h00, ctrl_reg[timerSel]} :
        (regOfs == reload_capture_timer16_pkg::FLAG_OFS)   ? {14'h0000, flag_reg[timerSel]} :
        (regOfs == reload_capture_timer16_pkg::RELOAD_OFS) ? reload_reg[timerSel] :
                                                             count_reg[timerSel];

    // Read data register, loaded in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= mapped ? {16'h0000, readSel} : 32'h00000000;
        end
    end

    // ==========================================================
    // Shared tick divider
    // ==========================================================
    logic divTick;

    tick_divider #(
        .DIV     (reload_capture_timer16_pkg::TICK_DIV_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (divTick)
    );

    // ==========================================================
    // Timer channels
    // ==========================================================
    // two independent timers
    for (genvar i = 0; i < NUM; i++) begin : g_timer
        logic        extLevel;
        logic        extRise;
        logic        extFall;
        logic        cntFall;
        logic        ctrlWr;
        logic        flagWr;
        logic        reloadWr;
        logic        countWr;
        logic        run;
        logic        capMode;
        logic        udEn;
        logic        countUp;
        logic        tick;
        logic        extEdge;
        logic        startEdge;
        logic        extEvent;
        logic [15:0] countNext;
        logic [15:0] reloadNext;
        logic [15:0] countInc;
        logic        ovfSet;
        logic        extSet;
        logic        extToggle;
        logic [1:0]  flagClr;
        logic [1:0]  flagNext;
        logic        runNext;

        // Trigger pin sampled every clock
        pin_edge_sampler u_ext (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .sampleEn (1'b1),
            .pinIn    (externalTriggerPin[i]),
            .level    (extLevel),
            .rise     (extRise),
            .fall     (extFall)
        );

        pin_edge_sampler u_cnt (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .sampleEn (divTick),
            .pinIn    (countInPin[i]),
            .level    (),
            .rise     (),
            .fall     (cntFall)
        );

        // Register write strobes for this timer
        assign ctrlWr   = apbWr & (timerSel == 1'(i))
                          & (regOfs == reload_capture_timer16_pkg::CTRL_OFS) & pstrb[0];
        assign flagWr   = apbWr & (timerSel == 1'(i))
                          & (regOfs == reload_capture_timer16_pkg::FLAG_OFS) & pstrb[0];
        assign reloadWr = apbWr & (timerSel == 1'(i))
                          & (regOfs == reload_capture_timer16_pkg::RELOAD_OFS);
        assign countWr  = apbWr & (timerSel == 1'(i))
                          & (regOfs == reload_capture_timer16_pkg::COUNT_OFS);

        // Mode decode
        assign run      = ctrl_reg[i][reload_capture_timer16_pkg::RUN_BIT];
        assign capMode  = ctrl_reg[i][reload_capture_timer16_pkg::CAP_SEL_BIT];
        assign udEn     = ctrl_reg[i][reload_capture_timer16_pkg::UPDOWN_BIT] & ~capMode;
        assign countUp  = ~udEn | extLevel;
        assign tick     = run & (ctrl_reg[i][reload_capture_timer16_pkg::COUNT_SRC_BIT]
                                 ? cntFall : divTick);
        assign countInc = count_reg[i] + 16'h0001;
        assign extEdge  = pickEdge(extRise, extFall,
                                   ctrl_reg[i][reload_capture_timer16_pkg::EXT_EDGE_BIT]);
        assign startEdge = ~run & ctrl_reg[i][reload_capture_timer16_pkg::HW_START_EN_BIT]
                           & pickEdge(extRise, extFall,
                                      ctrl_reg[i][reload_capture_timer16_pkg::HW_START_EDGE_BIT]);
        // Start edge itself does not reload or capture
        assign extEvent = ctrl_reg[i][reload_capture_timer16_pkg::EXT_EN_BIT]
                          & extEdge & ~startEdge;

        // Count, reload and event computation
        always_comb begin
            countNext  = count_reg[i];
            reloadNext = reload_reg[i];
            ovfSet     = 1'b0;
            extSet     = startEdge & ctrl_reg[i][reload_capture_timer16_pkg::EXT_EN_BIT];
            extToggle  = 1'b0;
            if (capMode) begin
                if (tick) begin
                    ovfSet    = (count_reg[i] == reload_capture_timer16_pkg::COUNT_MAX);
                    countNext = ovfSet ? reload_capture_timer16_pkg::CAPTURE_RESTART : countInc;
                end
                if (extEvent) begin
                    reloadNext = countNext;
                    extSet     = 1'b1;
                end
            end else if (extEvent & ~udEn) begin
                countNext = reload_reg[i];
                extSet    = 1'b1;
            end else if (tick & countUp) begin
                ovfSet    = (count_reg[i] == reload_capture_timer16_pkg::COUNT_MAX);
                countNext = ovfSet ? reload_reg[i] : countInc;
                extToggle = ovfSet & udEn;
            end else if (tick) begin
                ovfSet    = (count_reg[i] == reload_reg[i]);
                countNext = ovfSet ? reload_capture_timer16_pkg::COUNT_MAX
                                   : count_reg[i] - 16'h0001;
                extToggle = ovfSet;
            end
            // Software write to the count register wins
            if (countWr) begin
                countNext = mergeBytes(count_reg[i], pwdata, pstrb);
            end
            if (reloadWr) begin
                reloadNext = mergeBytes(reload_reg[i], pwdata, pstrb);
            end
        end

        // sticky flags (ext flag toggles on up/down wrap), write one clears, set wins
        assign flagClr  = flagWr ? pwdata[1:0] : 2'b00;
        assign flagNext = {((flag_reg[i][reload_capture_timer16_pkg::EXT_FLAG_BIT]
                             & ~flagClr[reload_capture_timer16_pkg::EXT_FLAG_BIT])
                            ^ extToggle) | extSet,
                           (flag_reg[i][reload_capture_timer16_pkg::OVF_FLAG_BIT]
                            & ~flagClr[reload_capture_timer16_pkg::OVF_FLAG_BIT]) | ovfSet};

        // software sets or clears run, hardware only sets
        assign runNext  = startEdge | (ctrlWr ? pwdata[reload_capture_timer16_pkg::RUN_BIT] : run);

        // Channel state registers
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                ctrl_reg[i]   <= reload_capture_timer16_pkg::CTRL_RESET;
                count_reg[i]  <= reload_capture_timer16_pkg::COUNT_RESET;
                reload_reg[i] <= reload_capture_timer16_pkg::RELOAD_RESET;
                flag_reg[i]   <= 2'b00;
            end else begin
                ctrl_reg[i]   <= {ctrlWr ? pwdata[7:1] : ctrl_reg[i][7:1], runNext};
                count_reg[i]  <= countNext;
                reload_reg[i] <= reloadNext;
                flag_reg[i]   <= flagNext;
            end
        end

        // request while a flag is set, not in up/down
        assign irqReq[i] = ~udEn & (|flag_reg[i]);  // Follows a mode change at once
    end : g_timer

endmodule : reload_capture_timer16

/* File: testbench/reload_capture_timer16_props.sv */
// Port assertions for the two-timer block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ns
module reload_capture_timer16_props #(
    parameter int NUM = 2
) (
    // Clock and reset
    input wire logic           sys_clk,
    input wire logic           rst_n,
    // APB
    input wire logic [7:0]     paddr,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [31:0]    pwdata,
    input wire logic [3:0]     pstrb,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    // Pins
    input wire logic [NUM-1:0] countInPin,
    input wire logic [NUM-1:0] externalTriggerPin,
    input wire logic [NUM-1:0] irqReq
);
    // ==========================================================
    // Decode
    // ==========================================================
    logic acc;
    logic badAd;
    logic t0Wr;
    logic upDnWr;
    // Access phase, refused address, timer 0 control and flag writes
    assign acc    = psel && penable;
    assign badAd  = (paddr >= 8'h20) || (paddr[1:0] != 2'h0);
    assign t0Wr   = acc && pwrite && (paddr == 8'h00 || paddr == 8'h04);
    assign upDnWr = t0Wr && !paddr[2] && pstrb[0]
        && pwdata[reload_capture_timer16_pkg::UPDOWN_BIT]
        && !pwdata[reload_capture_timer16_pkg::CAP_SEL_BIT];

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ready_always_a: assert property (pready)
        else $error("pready low");
    bad_addr_a: assert property (acc && badAd |-> pslverr)
        else $error("refused access without error");
    good_addr_a: assert property (acc && !badAd |-> !pslverr)
        else $error("error on mapped access");
    err_access_a: assert property (pslverr |-> acc)
        else $error("error outside access phase");
    upper_zero_a: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    bad_read_a: assert property (psel && !penable && !pwrite && badAd |=> prdata == 32'h0)
        else $error("refused read returned data");
    reset_quiet_a: assert property ($rose(rst_n) |-> irqReq == '0 && prdata == 32'h0)
        else $error("outputs not idle after reset");
    irq_sticky_a: assert property ($fell(irqReq[0]) |-> $past(t0Wr))
        else $error("request dropped without software write");
    updown_quiet_a: assert property (upDnWr |=> (!irqReq[0]) [*2])
        else $error("request raised in up/down mode");
    // Main scenarios reached
    cover property (acc && pslverr);
    cover property ($rose(irqReq[0]));
    cover property ($rose(irqReq[1]) || upDnWr);
endmodule : reload_capture_timer16_props

bind reload_capture_timer16 reload_capture_timer16_props #(.NUM(NUM)) props (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countInPin(countInPin), .externalTriggerPin(externalTriggerPin),
    .irqReq(irqReq));

/* File: testbench/timer_pin_model.sv */
// Model of the count and trigger pins feeding each timer.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/1ns
module timer_pin_model #(
    parameter int NUM = 2
) (
    // Clock and reset
    input  wire logic           sys_clk,
    input  wire logic           rst_n,
    // Commands from the bench
    input  wire logic [NUM-1:0] countRun,
    input  wire logic [NUM-1:0] trigLevel,
    // Pins into the timer
    output logic      [NUM-1:0] countInPin,
    output logic      [NUM-1:0] externalTriggerPin
);
    logic [4:0] phase_reg [NUM];
    // one falling edge per 24 clocks, whole periods only
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NUM; i++) begin
            if (!rst_n || phase_reg[i] == 5'h17)
                phase_reg[i] <= 5'h00;
            else if (countRun[i] || phase_reg[i] != 5'h00)
                phase_reg[i] <= phase_reg[i] + 5'h01;
        end
        externalTriggerPin <= rst_n ? trigLevel : '1;
    end
    // Count pin high in the first half of a period
    always_comb begin
        for (int i = 0; i < NUM; i++)
            countInPin[i] = (phase_reg[i] < 5'h0c);
    end
endmodule : timer_pin_model

/* File: testbench/reload_capture_timer16_test.sv */
// Self-checking bench for the two-timer block over APB.
// Assumes the pin model drives the pins of both timers.
`timescale 1ns/1ns
module reload_capture_timer16_test;
    localparam int T = 8;
    localparam logic [31:0] RUN = 32'h1 << reload_capture_timer16_pkg::RUN_BIT;
    localparam logic [31:0] CAP = 32'h1 << reload_capture_timer16_pkg::CAP_SEL_BIT;
    localparam logic [31:0] UPDN = 32'h1 << reload_capture_timer16_pkg::UPDOWN_BIT;
    localparam logic [31:0] EXTEN = 32'h1 << reload_capture_timer16_pkg::EXT_EN_BIT;
    localparam logic [31:0] CSRC = 32'h1 << reload_capture_timer16_pkg::COUNT_SRC_BIT;
    localparam logic [31:0] HWEN = 32'h1 << reload_capture_timer16_pkg::HW_START_EN_BIT;
    localparam logic [31:0] HWRISE = 32'h1 << reload_capture_timer16_pkg::HW_START_EDGE_BIT;
    localparam logic [31:0] EXRISE = 32'h1 << reload_capture_timer16_pkg::EXT_EDGE_BIT;
    localparam logic [31:0] OVF = 32'h1 << reload_capture_timer16_pkg::OVF_FLAG_BIT;
    localparam logic [31:0] EXT = 32'h1 << reload_capture_timer16_pkg::EXT_FLAG_BIT;
    localparam logic [3:0]  CT = reload_capture_timer16_pkg::CTRL_OFS;
    localparam logic [3:0]  FL = reload_capture_timer16_pkg::FLAG_OFS;
    localparam logic [3:0]  RL = reload_capture_timer16_pkg::RELOAD_OFS;
    localparam logic [3:0]  CN = reload_capture_timer16_pkg::COUNT_OFS;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, rd, v;
    logic [1:0]  countInPin, externalTriggerPin, irqReq, countRun, trigLevel;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    time         t1;

    // ==========================================================
    // Design and pin model
    // ==========================================================
    reload_capture_timer16 #(.NUM(2)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .countInPin(countInPin), .externalTriggerPin(externalTriggerPin),
        .irqReq(irqReq));
    timer_pin_model #(.NUM(2)) pins (
        .sys_clk(sys_clk), .rst_n(rst_n), .countRun(countRun), .trigLevel(trigLevel),
        .countInPin(countInPin), .externalTriggerPin(externalTriggerPin));

    // ==========================================================
    // Clock, timeout and helpers
    // ==========================================================
    initial begin
        sys_clk = 1'b0;
        forever #(T / 2) sys_clk = ~sys_clk;
    end
    // Cut a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    function automatic logic [7:0] ad(input int t, input logic [3:0] o);
        return 8'(t) * reload_capture_timer16_pkg::TIMER_STRIDE + 8'(o);
    endfunction : ad
    // One APB transfer, held until pready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask : rc
    task automatic waitIrq(input int i);
        int n = 0;
        while (irqReq[i] !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        chk("irq raised", 32'(irqReq[i]), 32'h1);
    endtask : waitIrq
    task automatic print_verdict;
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        {psel, penable, pwrite, paddr, pwdata, countRun} = '0;
        pstrb = 4'hf;
        trigLevel = 2'h3;
        rst_n = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values, then refused accesses
        for (int a = 0; a < 32; a += 4)
            rc("reset value", 8'(a), 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        bus(1'b1, 8'h02, RUN);
        chk("misaligned err", 32'(err), 32'h1);
        rc("ctrl kept", ad(0, CT), 32'h0);
        // Timer mode overflow, reload and tick period
        bus(1'b1, ad(0, RL), 32'hfff0);
        bus(1'b1, ad(0, CN), 32'hfff0);
        bus(1'b1, ad(0, CT), RUN);
        waitIrq(0);
        t1 = $time;
        rc("reloaded count", ad(0, CN), 32'hfff0);
        rc("overflow flag", ad(0, FL), OVF);
        rc("still running", ad(0, CT), RUN);
        bus(1'b1, ad(0, FL), OVF);
        @(posedge sys_clk);
        chk("irq cleared", 32'(irqReq[0]), 32'h0);
        waitIrq(0);
        chk("tick period", 32'(($time - t1) / T), 32'h0c * 16);
        bus(1'b1, ad(0, CT), 32'h0);
        bus(1'b0, ad(0, CN), 32'h0);
        v = rd;
        repeat (40) @(posedge sys_clk);
        rc("stopped count", ad(0, CN), v);
        // Falling trigger edge, reload enabled and disabled
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, ad(0, FL), OVF | EXT);
            bus(1'b1, ad(0, RL), 32'h1234);
            bus(1'b1, ad(0, CN), 32'h0100);
            bus(1'b1, ad(0, CT), e ? (RUN | EXTEN) : RUN);
            trigLevel[0] <= 1'b0;
            repeat (6) @(posedge sys_clk);
            bus(1'b0, ad(0, CN), 32'h0);
            v = e ? 32'h1234 : 32'h0100;
            chk("edge reload", 32'(rd >= v && rd <= v + 2), 32'h1);
            rc("edge flag", ad(0, FL), e ? EXT : 32'h0);
            chk("edge irq", 32'(irqReq[0]), 32'(e));
            trigLevel[0] <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
        // Up/down: down through underflow, then up
        bus(1'b1, ad(0, CT), 32'h0);
        bus(1'b1, ad(0, FL), OVF | EXT);
        bus(1'b1, ad(0, CN), 32'hfff2);
        trigLevel[0] <= 1'b0;
        bus(1'b1, ad(0, RL), 32'hfff0);
        bus(1'b1, ad(0, CT), RUN | UPDN);
        repeat (60) @(posedge sys_clk);
        bus(1'b0, ad(0, CN), 32'h0);
        chk("down wrap", 32'(rd >= 32'hfff8), 32'h1);
        bus(1'b0, ad(0, FL), 32'h0);
        chk("underflow flag", rd & OVF, OVF);
        chk("no updown irq", 32'(irqReq[0]), 32'h0);
        trigLevel[0] <= 1'b1;
        bus(1'b1, ad(0, CN), 32'h1000);
        repeat (4) @(posedge sys_clk);
        bus(1'b0, ad(0, CN), 32'h0);
        v = rd;
        repeat (36) @(posedge sys_clk);
        bus(1'b0, ad(0, CN), 32'h0);
        chk("up count", 32'(rd - v >= 2 && rd - v <= 4), 32'h1);
        // Capture mode wraps at ffff and captures on a rising edge
        bus(1'b1, ad(0, CT), 32'h0);
        bus(1'b1, ad(0, FL), OVF | EXT);
        bus(1'b1, ad(0, CN), 32'hfffe);
        bus(1'b1, ad(0, CT), RUN | CAP | EXTEN | EXRISE);
        repeat (40) @(posedge sys_clk);
        bus(1'b0, ad(0, CN), 32'h0);
        chk("capture wrap", 32'(rd <= 32'h0004), 32'h1);
        rc("capture ovf", ad(0, FL), OVF);
        trigLevel[0] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rc("fall ignored", ad(0, FL), OVF);
        trigLevel[0] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rc("capture flag", ad(0, FL), OVF | EXT);
        bus(1'b0, ad(0, RL), 32'h0);
        chk("captured", 32'(rd <= 32'h0008), 32'h1);
        chk("capture irq", 32'(irqReq[0]), 32'h1);
        // Hardware start of timer 1 on a rising edge only
        bus(1'b1, ad(1, CT), HWEN | HWRISE);
        trigLevel[1] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rc("no start on fall", ad(1, CT), HWEN | HWRISE);
        trigLevel[1] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rc("hw start", ad(1, CT), RUN | HWEN | HWRISE);
        // Counter mode on timer 1, ten pin pulses
        bus(1'b1, ad(1, CT), RUN | CSRC);
        bus(1'b1, ad(1, CN), 32'h0);
        countRun[1] <= 1'b1;
        repeat (240) @(posedge sys_clk);
        countRun[1] <= 1'b0;
        repeat (48) @(posedge sys_clk);
        rc("pin count", ad(1, CN), 32'ha);
        chk("timer 1 quiet", 32'(irqReq[1]), 32'h0);
        rc("timer 0 kept", ad(0, CT), RUN | CAP | EXTEN | EXRISE);
        print_verdict();
    end
endmodule : reload_capture_timer16_test
